// ===== timer_pin_defines.svh
// offsets, field positions, reset values and widths of the timer pin and interrupt-enable block
`ifndef TIMER_PIN_DEFINES_SVH
`define TIMER_PIN_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_IRQ_ENABLE 4'h0
`define REG_IO_CTRL_AB 4'h1
`define REG_IO_CTRL_CD 4'h2
`define REG_INIT_LEVEL 4'h3
`define REG_PORT_DIR 4'h4
`define REG_EVT_STATUS 4'h5
`define REG_EVT_MASK 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define IRQ_EN_OVERFLOW_BIT 7
`define IRQ_EN_D_BIT 3
`define IRQ_EN_C_BIT 2
`define IRQ_EN_B_BIT 1
`define IRQ_EN_A_BIT 0
`define IO_SEL_LO_LSB 0
`define IO_SEL_HI_LSB 4
`define INIT_LEVEL_A_BIT 0
`define DIR_PIN1_BIT 1
`define DIR_PIN2_BIT 2
`define DIR_PIN3_BIT 3
`define EVT_WIDTH 5

// ----------------------------------------
// reset and fixed values
// ----------------------------------------
`define IRQ_EN_RESET 8'h00
`define IRQ_EN_RSVD_ONES 8'h70
`define IRQ_EN_WRITABLE 8'h8F
`define IO_CTRL_RESET 8'h00
`define INIT_LEVEL_RESET 1'h0
`define PORT_DIR_RESET 8'h00
`define EVT_RESET 5'h00

`endif

// ===== timer_pin_pkg.sv
// types and pin-mode decoding for the timer pin and interrupt-enable block
package timer_pin_pkg;

    // ----------------------------------------
    // pin function
    // ----------------------------------------
    typedef enum logic [2:0] {
        PIN_PORT_IN = 3'b001,
        PIN_PORT_OUT = 3'b010,
        PIN_TIMER_OUT = 3'b100
    } pin_mode_type;

    // 001 and 01x give the timer the pin; 000 and 1xx leave it to the port
    function automatic pin_mode_type pin_mode(input logic [2:0] io_sel, input logic port_dir);
        if (io_sel[2] == 1'b0 && io_sel[1:0] != 2'b00) begin
            return PIN_TIMER_OUT;
        end
        return port_dir ? PIN_PORT_OUT : PIN_PORT_IN;
    endfunction : pin_mode

endpackage : timer_pin_pkg

// ===== pin_select.sv
// one shared timer/port pin: function select, drive and capture feed
`timescale 1ns/100ps
module pin_select (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic [2:0] io_sel,
    input wire logic port_dir,
    // levels to drive
    input wire logic port_data,
    input wire logic timer_level,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    // capture feed, always connected
    output logic capture_o
);

    timer_pin_pkg::pin_mode_type mode;

    assign mode = timer_pin_pkg::pin_mode(io_sel, port_dir);

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_o <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            unique case (mode)
                timer_pin_pkg::PIN_TIMER_OUT: begin
                    pin_o <= timer_level;
                    pin_oe <= 1'b1;
                end
                timer_pin_pkg::PIN_PORT_OUT: begin
                    pin_o <= port_data;
                    pin_oe <= 1'b1;
                end
                timer_pin_pkg::PIN_PORT_IN: begin
                    pin_o <= 1'b0;
                    pin_oe <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // capture feed
    // ----------------------------------------
    // the timer still sees the pin as a port; in output mode it sees its own drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_o <= 1'b0;
        end else begin
            capture_o <= pin_oe ? pin_o : pin_i;
        end
    end

endmodule : pin_select

// ===== timer_pin_irq.sv
// timer pin function select, channel A initial level and interrupt-enable register
`timescale 1ns/100ps
`include "timer_pin_defines.svh"

module timer_pin_irq #(
    parameter int ADDR_WIDTH = 4,
    parameter int DATA_WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [DATA_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_WIDTH-1:0] reg_rdata,
    // status flags from the timer datapath
    input wire logic counter_overflow_flag,
    input wire logic chan_a_match_flag,
    input wire logic chan_b_match_flag,
    input wire logic chan_c_match_flag,
    input wire logic chan_d_match_flag,
    // compare output levels from the timer datapath
    input wire logic chan_a_compare_match,
    input wire logic chan_a_compare_level,
    input wire logic chan_b_out_level,
    input wire logic chan_c_out_level,
    // port data for pins in port mode
    input wire logic port8_pin1_data,
    input wire logic port8_pin2_data,
    input wire logic port8_pin3_data,
    // shared pins
    input wire logic timer_pin_chan_a_i,
    output logic timer_pin_chan_a_o,
    output logic timer_pin_chan_a_oe,
    input wire logic timer_pin_chan_b_i,
    output logic timer_pin_chan_b_o,
    output logic timer_pin_chan_b_oe,
    input wire logic timer_pin_chan_c_i,
    output logic timer_pin_chan_c_o,
    output logic timer_pin_chan_c_oe,
    // capture inputs to the timer
    output logic chan_a_capture_in,
    output logic chan_b_capture_in,
    output logic chan_c_capture_in,
    // gated requests to the interrupt controller
    output logic overflow_irq_request,
    output logic chan_a_irq_request,
    output logic chan_b_irq_request,
    output logic chan_c_irq_request,
    output logic chan_d_irq_request,
    // summary interrupt
    output logic irq
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    generate
        if (DATA_WIDTH != 8 || ADDR_WIDTH < 3) begin : g_bad_params
            $error("timer_pin_irq needs DATA_WIDTH of 8 and ADDR_WIDTH of at least 3");
        end
    endgenerate

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [7:0] irq_enable_q;
    logic [7:0] io_ctrl_ab_q;
    logic [7:0] io_ctrl_cd_q;
    logic chan_a_initial_level_q;
    logic [7:0] port8_direction_q;
    logic [`EVT_WIDTH-1:0] evt_status_q;
    logic [`EVT_WIDTH-1:0] evt_status_d;
    logic [`EVT_WIDTH-1:0] evt_mask_q;
    logic [`EVT_WIDTH-1:0] flag_prev_q;
    logic [`EVT_WIDTH-1:0] flags;
    logic [`EVT_WIDTH-1:0] evt_rise;
    logic chan_a_matched_q;
    logic chan_a_level;
    logic [7:0] read_value;

    // ----------------------------------------
    // flag vector
    // ----------------------------------------
    // same bit order as the event status and mask registers
    assign flags = {counter_overflow_flag, chan_d_match_flag, chan_c_match_flag, chan_b_match_flag,
                    chan_a_match_flag};

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // exact match: a partial decode would let aliases land writes in the wrong register
    function automatic logic hit(input logic [ADDR_WIDTH-1:0] addr, input logic [3:0] offset);
        return addr == ADDR_WIDTH'(offset);
    endfunction : hit

    // ----------------------------------------
    // interrupt enable register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable_q <= `IRQ_EN_RESET;
        end else if (reg_write && hit(reg_addr, `REG_IRQ_ENABLE)) begin
            irq_enable_q <= reg_wdata & `IRQ_EN_WRITABLE;
        end
    end

    // ----------------------------------------
    // io control and port direction
    // ----------------------------------------
    // unused select bits are kept so software reads back what it wrote
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            io_ctrl_ab_q <= `IO_CTRL_RESET;
            io_ctrl_cd_q <= `IO_CTRL_RESET;
            port8_direction_q <= `PORT_DIR_RESET;
        end else if (reg_write) begin
            if (hit(reg_addr, `REG_IO_CTRL_AB)) begin
                io_ctrl_ab_q <= reg_wdata;
            end
            if (hit(reg_addr, `REG_IO_CTRL_CD)) begin
                io_ctrl_cd_q <= reg_wdata;
            end
            if (hit(reg_addr, `REG_PORT_DIR)) begin
                port8_direction_q <= reg_wdata;
            end
        end
    end

    // ----------------------------------------
    // channel A initial level
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_a_initial_level_q <= `INIT_LEVEL_RESET;
        end else if (reg_write && hit(reg_addr, `REG_INIT_LEVEL)) begin
            chan_a_initial_level_q <= reg_wdata[`INIT_LEVEL_A_BIT];
        end
    end

    // a new initial level hands the pin back to it, unless a match lands the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_a_matched_q <= 1'b0;
        end else if (chan_a_compare_match) begin
            chan_a_matched_q <= 1'b1;
        end else if (reg_write && hit(reg_addr, `REG_INIT_LEVEL)) begin
            chan_a_matched_q <= 1'b0;
        end
    end

    assign chan_a_level = chan_a_matched_q ? chan_a_compare_level : chan_a_initial_level_q;

    // ----------------------------------------
    // shared pins
    // ----------------------------------------
    // channel A takes its own level; B and C follow the datapath's compare outputs
    pin_select u_pin_a (
        .clk(clk),
        .rst(rst),
        .io_sel(io_ctrl_ab_q[`IO_SEL_LO_LSB +: 3]),
        .port_dir(port8_direction_q[`DIR_PIN1_BIT]),
        .port_data(port8_pin1_data),
        .timer_level(chan_a_level),
        .pin_i(timer_pin_chan_a_i),
        .pin_o(timer_pin_chan_a_o),
        .pin_oe(timer_pin_chan_a_oe),
        .capture_o(chan_a_capture_in)
    );

    pin_select u_pin_b (
        .clk(clk),
        .rst(rst),
        .io_sel(io_ctrl_ab_q[`IO_SEL_HI_LSB +: 3]),
        .port_dir(port8_direction_q[`DIR_PIN2_BIT]),
        .port_data(port8_pin2_data),
        .timer_level(chan_b_out_level),
        .pin_i(timer_pin_chan_b_i),
        .pin_o(timer_pin_chan_b_o),
        .pin_oe(timer_pin_chan_b_oe),
        .capture_o(chan_b_capture_in)
    );

    pin_select u_pin_c (
        .clk(clk),
        .rst(rst),
        .io_sel(io_ctrl_cd_q[`IO_SEL_LO_LSB +: 3]),
        .port_dir(port8_direction_q[`DIR_PIN3_BIT]),
        .port_data(port8_pin3_data),
        .timer_level(chan_c_out_level),
        .pin_i(timer_pin_chan_c_i),
        .pin_o(timer_pin_chan_c_o),
        .pin_oe(timer_pin_chan_c_oe),
        .capture_o(chan_c_capture_in)
    );

    // ----------------------------------------
    // gated requests
    // ----------------------------------------
    // registered so the requests leave flops; one cycle later than the flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_irq_request <= 1'b0;
            chan_a_irq_request <= 1'b0;
            chan_b_irq_request <= 1'b0;
            chan_c_irq_request <= 1'b0;
            chan_d_irq_request <= 1'b0;
        end else begin
            overflow_irq_request <= counter_overflow_flag & irq_enable_q[`IRQ_EN_OVERFLOW_BIT];
            chan_d_irq_request <= chan_d_match_flag & irq_enable_q[`IRQ_EN_D_BIT];
            chan_c_irq_request <= chan_c_match_flag & irq_enable_q[`IRQ_EN_C_BIT];
            chan_b_irq_request <= chan_b_match_flag & irq_enable_q[`IRQ_EN_B_BIT];
            chan_a_irq_request <= chan_a_match_flag & irq_enable_q[`IRQ_EN_A_BIT];
        end
    end

    // ----------------------------------------
    // sticky event status and summary interrupt
    // ----------------------------------------
    assign evt_rise = flags & ~flag_prev_q;

    // set beats a write-one-to-clear in the same cycle
    always_comb begin
        evt_status_d = evt_status_q;
        if (reg_write && hit(reg_addr, `REG_EVT_STATUS)) begin
            evt_status_d = evt_status_d & ~reg_wdata[`EVT_WIDTH-1:0];
        end
        evt_status_d = evt_status_d | evt_rise;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_prev_q <= `EVT_RESET;
            evt_status_q <= `EVT_RESET;
        end else begin
            flag_prev_q <= flags;
            evt_status_q <= evt_status_d;
        end
    end

    // the mask shapes irq only; the per-source requests ignore it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_mask_q <= `EVT_RESET;
        end else if (reg_write && hit(reg_addr, `REG_EVT_MASK)) begin
            evt_mask_q <= reg_wdata[`EVT_WIDTH-1:0];
        end
    end

    // built from the next status so irq rises in the same cycle as its bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status_d & evt_mask_q);
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        read_value = 8'h00;
        if (hit(reg_addr, `REG_IRQ_ENABLE)) begin
            read_value = irq_enable_q | `IRQ_EN_RSVD_ONES;
        end else if (hit(reg_addr, `REG_IO_CTRL_AB)) begin
            read_value = io_ctrl_ab_q;
        end else if (hit(reg_addr, `REG_IO_CTRL_CD)) begin
            read_value = io_ctrl_cd_q;
        end else if (hit(reg_addr, `REG_INIT_LEVEL)) begin
            read_value = {7'h00, chan_a_initial_level_q};
        end else if (hit(reg_addr, `REG_PORT_DIR)) begin
            read_value = port8_direction_q;
        end else if (hit(reg_addr, `REG_EVT_STATUS)) begin
            read_value = {3'h0, evt_status_q};
        end else if (hit(reg_addr, `REG_EVT_MASK)) begin
            read_value = {3'h0, evt_mask_q};
        end
    end

    // data stand only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_read ? read_value : 8'h00;
        end
    end

endmodule : timer_pin_irq

// ===== timer_pin_irq_chk.sv
// port-level assertions for the timer pin and interrupt-enable block
`timescale 1ns/100ps
module timer_pin_irq_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // flags and gated requests
    input wire logic counter_overflow_flag,
    input wire logic chan_a_match_flag,
    input wire logic chan_b_match_flag,
    input wire logic chan_c_match_flag,
    input wire logic chan_d_match_flag,
    input wire logic overflow_irq_request,
    input wire logic chan_a_irq_request,
    input wire logic chan_b_irq_request,
    input wire logic chan_c_irq_request,
    input wire logic chan_d_irq_request,
    // channel a pin
    input wire logic timer_pin_chan_a_i,
    input wire logic timer_pin_chan_a_o,
    input wire logic timer_pin_chan_a_oe,
    input wire logic chan_a_capture_in
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // level the pin really carried last cycle
    logic cap_src_q;
    always_ff @(posedge clk, posedge rst) begin
        if (rst) begin
            cap_src_q <= 1'b0;
        end else begin
            cap_src_q <= timer_pin_chan_a_oe ? timer_pin_chan_a_o : timer_pin_chan_a_i;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    rsvd_ones_a: assert property (reg_read && reg_addr == 4'h0 |=> reg_rdata[6:4] == 3'h7)
        else $error("reserved enable bits not read as one");
    overflow_gate_a: assert property (overflow_irq_request |-> $past(counter_overflow_flag))
        else $error("overflow request without overflow flag");
    d_gate_a: assert property ($fell(chan_d_match_flag) |=> !chan_d_irq_request)
        else $error("channel d request outlives its flag");
    c_gate_a: assert property (!chan_c_match_flag [*2] |-> !chan_c_irq_request)
        else $error("channel c request without flag");
    b_gate_a: assert property (chan_b_irq_request |-> $past(chan_b_match_flag))
        else $error("channel b request without flag");
    a_gate_a: assert property (!chan_a_match_flag |=> !chan_a_irq_request)
        else $error("channel a request without flag");
    capture_feed_a: assert property (!$past(rst) |-> chan_a_capture_in == cap_src_q)
        else $error("channel a capture input lost the pin level");
    reset_quiet_a: assert property ($fell(rst) |-> !timer_pin_chan_a_o && !overflow_irq_request)
        else $error("outputs not idle after reset");
endmodule : timer_pin_irq_chk

// ===== pin_far_end.sv
// outside circuit on one shared timer pin
`timescale 1ns/100ps
module pin_far_end (
    // device side
    input wire logic pin_o,
    input wire logic pin_oe,
    // level held outside while the device lets go
    input wire logic ext_level,
    // level seen on the wire
    output logic pin_i
);
    // resistive outside drive: the device wins while enabled
    assign pin_i = pin_oe ? pin_o : ext_level;
endmodule : pin_far_end

// ===== timer_pin_irq_bench.sv
// self-checking bench for the timer pin and interrupt-enable block
`timescale 1ns/100ps
module timer_pin_irq_bench;
    logic clk, rst, reg_write, reg_read, cmp_match, cmp_level, irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] flag, req;
    logic [2:0] pin_o, pin_oe, pin_i, cap, ext, pdata;
    logic [1:0] lvl_bc;
    logic [31:0] seed = 32'hEFA6A554;
    logic [31:0] r;
    int n_fail = 0;
    int checked = 0;

    timer_pin_irq i_timer_pin_irq (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .counter_overflow_flag(flag[4]), .chan_a_match_flag(flag[0]), .chan_b_match_flag(flag[1]),
        .chan_c_match_flag(flag[2]), .chan_d_match_flag(flag[3]), .chan_a_compare_match(cmp_match),
        .chan_a_compare_level(cmp_level), .chan_b_out_level(lvl_bc[0]), .chan_c_out_level(lvl_bc[1]),
        .port8_pin1_data(pdata[0]), .port8_pin2_data(pdata[1]), .port8_pin3_data(pdata[2]),
        .timer_pin_chan_a_i(pin_i[0]), .timer_pin_chan_a_o(pin_o[0]), .timer_pin_chan_a_oe(pin_oe[0]),
        .timer_pin_chan_b_i(pin_i[1]), .timer_pin_chan_b_o(pin_o[1]), .timer_pin_chan_b_oe(pin_oe[1]),
        .timer_pin_chan_c_i(pin_i[2]), .timer_pin_chan_c_o(pin_o[2]), .timer_pin_chan_c_oe(pin_oe[2]),
        .chan_a_capture_in(cap[0]), .chan_b_capture_in(cap[1]), .chan_c_capture_in(cap[2]),
        .overflow_irq_request(req[4]), .chan_a_irq_request(req[0]), .chan_b_irq_request(req[1]),
        .chan_c_irq_request(req[2]), .chan_d_irq_request(req[3]), .irq(irq));

    for (genvar g = 0; g < 3; g++) begin : g_far
        pin_far_end i_pin_far_end (.pin_o(pin_o[g]), .pin_oe(pin_oe[g]), .ext_level(ext[g]), .pin_i(pin_i[g]));
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic is_timer(input logic [2:0] sel);
        return sel[2] == 1'b0 && sel[1:0] != 2'b00;
    endfunction : is_timer

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask : rd

    task automatic pin_case(input logic [2:0] sel, input logic dir);
        logic [2:0] eo, eoe, tl;
        r = xs();
        @(posedge clk);
        {pdata, lvl_bc, ext} <= r[7:0];
        wr(4'h1, {1'b0, sel, 1'b0, sel});
        wr(4'h2, {5'h00, sel});
        wr(4'h3, {7'h00, r[8]});
        wr(4'h4, {4'h0, {3{dir}}, 1'b0});
        tick(4);
        tl = {lvl_bc, r[8]};
        for (int k = 0; k < 3; k++) begin
            eoe[k] = is_timer(sel) | dir;
            eo[k] = is_timer(sel) ? tl[k] : dir & pdata[k];
        end
        check("pin level", {5'h00, pin_o}, {5'h00, eo});
        check("pin enable", {5'h00, pin_oe}, {5'h00, eoe});
        check("capture", {5'h00, cap}, {5'h00, (eoe & eo) | (~eoe & ext)});
    endtask : pin_case

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // a hang must not pass silently
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end

    initial begin
        {rst, reg_write, reg_read, cmp_match, cmp_level, reg_addr, reg_wdata} = {1'b1, 16'h0000};
        {flag, pdata, lvl_bc, ext} = 13'h0000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 8'h70, "enable after reset");
        rd(4'h3, 8'h00, "init level after reset");
        check("pin a after reset", {7'h00, pin_o[0]}, 8'h00);
        rd(4'hF, 8'h00, "unmapped read");
        $display("test reset done");
        repeat (24) begin
            r = xs();
            wr(4'h0, r[7:0]);
            @(posedge clk);
            flag <= r[12:8];
            tick(3);
            check("requests", {3'h0, req}, {3'h0, r[12:8] & {r[7], r[3:0]}});
            rd(4'h0, (r[7:0] & 8'h8F) | 8'h70, "enable readback");
        end
        $display("test gating done");
        for (int s = 0; s < 16; s++) begin
            pin_case(s[3:1], s[0]);
        end
        $display("test pin modes done");
        wr(4'h1, 8'h01);
        wr(4'h4, 8'h00);
        wr(4'h3, 8'h01);
        tick(2);
        check("initial level high", {7'h00, pin_o[0]}, 8'h01);
        @(posedge clk);
        cmp_match <= 1'b1;
        @(posedge clk);
        cmp_match <= 1'b0;
        tick(2);
        check("level after match", {7'h00, pin_o[0]}, 8'h00);
        @(posedge clk);
        cmp_level <= 1'b1;
        tick(2);
        check("compare level", {7'h00, pin_o[0]}, 8'h01);
        @(posedge clk);
        cmp_level <= 1'b0;
        wr(4'h3, 8'h01);
        tick(2);
        check("rewrite after match", {7'h00, pin_o[0]}, 8'h01);
        $display("test initial level done");
        @(posedge clk);
        flag <= 5'h00;
        wr(4'h5, 8'h1F);
        wr(4'h6, 8'h01);
        @(posedge clk);
        flag <= 5'h01;
        tick(3);
        check("irq raised", {7'h00, irq}, 8'h01);
        rd(4'h5, 8'h01, "event status");
        wr(4'h6, 8'h00);
        tick(2);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(4'h6, 8'h01);
        wr(4'h5, 8'h01);
        tick(2);
        check("irq cleared", {7'h00, irq}, 8'h00);
        $display("test events done");
        summarize();
    end
endmodule : timer_pin_irq_bench

bind timer_pin_irq timer_pin_irq_chk i_timer_pin_irq_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .counter_overflow_flag(counter_overflow_flag),
    .chan_a_match_flag(chan_a_match_flag), .chan_b_match_flag(chan_b_match_flag),
    .chan_c_match_flag(chan_c_match_flag), .chan_d_match_flag(chan_d_match_flag),
    .overflow_irq_request(overflow_irq_request), .chan_a_irq_request(chan_a_irq_request),
    .chan_b_irq_request(chan_b_irq_request), .chan_c_irq_request(chan_c_irq_request),
    .chan_d_irq_request(chan_d_irq_request), .timer_pin_chan_a_i(timer_pin_chan_a_i),
    .timer_pin_chan_a_o(timer_pin_chan_a_o), .timer_pin_chan_a_oe(timer_pin_chan_a_oe),
    .chan_a_capture_in(chan_a_capture_in));
